// file: core/swc_dev.sv
// Function
// - Latch speed field immediately, even without activity
// - Bit7 and bit0 set; bits 6..5 function
// - Bits 3..2 speed; pulse needs 11
// - Reset response: 11, revision, bus result
// - Reset response bit 5 reserved, undefined
// - Host issues bus reset before communication
// - Single bit: one slot, bit4 selects type
// - Slot response 100, echo, sampled bit twice
// - Bit1 set: pullup, then EFh or ECh
// - Accelerator flag from bit4 drives search
// - Accelerator command: no activity, no response
// - Host disarms pullup before enabling accelerator
// - Pulse bit1 arms, bit4 selects 12V
// - Pulse length from configuration, zero unlimited
// - Host never combines unlimited with arming
// - F1h in command mode ends pulse
// - Pulse end response echoes command, low undefined
// - Armed data byte adds F6h or 76h
// - Host avoids arming inside programming pulse
// - E1h, E3h, F1h send no response
// - Check mode: repeated E3h written as data
// - Illegal command byte sends no response
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module swc_dev (
  input wire logic CLK_I,
  input wire logic RESET_I,
  swc_link_if.dev LINK,
  input wire logic [15:0] PULSE_CYCLES_I,
  input wire logic BUS_DONE_I,
  input wire logic [7:0] BUS_RESULT_I,
  input wire logic BUS_DEMAND_END_I,
  output logic BUS_RESET_O,
  output logic BUS_SLOT_O,
  output logic BUS_SLOT_BIT_O,
  output logic BUS_BYTE_O,
  output logic [7:0] BUS_DATA_O,
  output logic [1:0] BUS_SPEED_O,
  output logic BUS_SEARCH_O,
  output logic BUS_PULLUP_O,
  output logic BUS_PROG_O,
  output logic DATA_MODE_O
);

  swc_pkg::swc_state_t state_q;
  swc_pkg::swc_kind_t kind_q;
  logic ready_q, rsp_valid_q;
  logic [7:0] rsp_byte_q, cmd_q, data_q;
  logic data_mode_q, check_q, arm_q, accel_q, opt_q, last_bit_q;
  logic [1:0] speed_q;
  logic bus_rst_q, slot_q, slot_bit_q, byte_q, pullup_q, prog_q;
  logic [15:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the incoming byte

  logic xfer, idle_take, exec, send_data, enter_check;
  logic is_comm, c_bit, c_acc, c_rst, c_pul, c_dm;
  logic [7:0] b;
  logic [1:0] fn, spd;
  logic pulse_end;

  assign b = LINK.cmd_byte;
  assign xfer = LINK.cmd_valid & ready_q;
  assign idle_take = xfer & (state_q == swc_pkg::ST_IDLE);
  // Check mode: a second E3h is data, anything else is a command
  assign exec = idle_take & (~data_mode_q | (check_q & (b != swc_pkg::CODE_CMD_MODE)));
  assign send_data = idle_take & data_mode_q
                     & (check_q ? (b == swc_pkg::CODE_CMD_MODE)
                                : (b != swc_pkg::CODE_CMD_MODE));
  assign enter_check = idle_take & data_mode_q & ~check_q & (b == swc_pkg::CODE_CMD_MODE);
  assign is_comm = b[swc_pkg::CMD_FLAG_HI] & b[swc_pkg::CMD_FLAG_LO];
  assign fn = b[swc_pkg::CMD_FN_HI:swc_pkg::CMD_FN_LO];
  assign c_bit = exec & is_comm & (fn == swc_pkg::FN_BIT);
  assign c_acc = exec & is_comm & (fn == swc_pkg::FN_ACCEL);
  assign c_rst = exec & is_comm & (fn == swc_pkg::FN_RESET);
  // Pulse with any speed code but 11 is treated as illegal, no response
  assign c_pul = exec & is_comm & (fn == swc_pkg::FN_PULSE)
                 & (b[swc_pkg::CMD_SPD_HI:swc_pkg::CMD_SPD_LO] == swc_pkg::SPD_PULSE);
  assign c_dm = exec & (b == swc_pkg::CODE_DATA_MODE);
  // Code 11 is an alias of regular speed
  assign spd = (b[swc_pkg::CMD_SPD_HI:swc_pkg::CMD_SPD_LO] == swc_pkg::SPD_ALIAS) ?
               swc_pkg::SPD_REGULAR : b[swc_pkg::CMD_SPD_HI:swc_pkg::CMD_SPD_LO];

  // Timeout, end of current demand or host stop, whichever first
  assign pulse_end = ((PULSE_CYCLES_I != swc_pkg::PULSE_UNLIMITED)
                      & ((cnt_q + 16'h0001) >= PULSE_CYCLES_I))
                     | BUS_DEMAND_END_I
                     | (xfer & (b == swc_pkg::CODE_PULSE_STOP));

  ////////////////////////////////////////////////////////////////////////////
  // Mode and persistent flags

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      data_mode_q <= 1'h0;
      check_q <= 1'h0;
    end else if (enter_check) begin
      check_q <= 1'h1;
    end else if (send_data) begin
      check_q <= 1'h0;
    end else if (exec) begin
      check_q <= 1'h0;
      data_mode_q <= c_dm;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      speed_q <= swc_pkg::SPD_REGULAR;
      accel_q <= 1'h0;
      arm_q <= 1'h0;
    end else begin
      if (c_bit | c_acc | c_rst) begin
        speed_q <= spd;
      end
      if (c_acc) begin
        accel_q <= b[swc_pkg::CMD_ARG];
      end
      if (c_pul) begin
        arm_q <= b[swc_pkg::CMD_OPT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_q <= swc_pkg::ST_IDLE;
      kind_q <= swc_pkg::K_RESET;
      ready_q <= 1'h0;
      rsp_valid_q <= 1'h0;
      rsp_byte_q <= 8'h00;
      cmd_q <= 8'h00;
      data_q <= 8'h00;
      opt_q <= 1'h0;
      last_bit_q <= 1'h0;
      bus_rst_q <= 1'h0;
      slot_q <= 1'h0;
      slot_bit_q <= 1'h0;
      byte_q <= 1'h0;
      pullup_q <= 1'h0;
      prog_q <= 1'h0;
      cnt_q <= 16'h0000;
    end else begin
      bus_rst_q <= 1'h0;
      slot_q <= 1'h0;
      byte_q <= 1'h0;
      rsp_valid_q <= 1'h0;
      unique case (state_q)
        swc_pkg::ST_IDLE: begin
          ready_q <= 1'h1;
          cmd_q <= b;
          if (send_data) begin
            byte_q <= 1'h1;
            data_q <= b;
            kind_q <= swc_pkg::K_DATA;
            ready_q <= 1'h0;
            state_q <= swc_pkg::ST_BUS;
          end else if (c_bit) begin
            slot_q <= 1'h1;
            slot_bit_q <= b[swc_pkg::CMD_ARG];
            opt_q <= b[swc_pkg::CMD_OPT];
            kind_q <= swc_pkg::K_BIT;
            ready_q <= 1'h0;
            state_q <= swc_pkg::ST_BUS;
          end else if (c_rst) begin
            bus_rst_q <= 1'h1;
            kind_q <= swc_pkg::K_RESET;
            ready_q <= 1'h0;
            state_q <= swc_pkg::ST_BUS;
          end else if (c_pul) begin
            // 12V on bit 4 set, else 5V pullup
            prog_q <= b[swc_pkg::CMD_ARG];
            pullup_q <= ~b[swc_pkg::CMD_ARG];
            kind_q <= swc_pkg::K_PULSE;
            cnt_q <= 16'h0000;
            state_q <= swc_pkg::ST_PULSE;
          end
        end
        swc_pkg::ST_BUS: begin
          if (BUS_DONE_I) begin
            rsp_valid_q <= 1'h1;
            last_bit_q <= BUS_RESULT_I[0];
            unique case (kind_q)
              swc_pkg::K_RESET: begin
                rsp_byte_q <= {swc_pkg::RSP_RESET_HEAD, swc_pkg::RSP_RESERVED,
                               swc_pkg::CHIP_REVISION, BUS_RESULT_I[1:0]};
              end
              swc_pkg::K_BIT: begin
                rsp_byte_q <= {swc_pkg::RSP_BIT_HEAD, cmd_q[4:2],
                               BUS_RESULT_I[0], BUS_RESULT_I[0]};
              end
              default: begin
                rsp_byte_q <= BUS_RESULT_I;
              end
            endcase
            // Per-slot or per-byte pullup follows the response
            if (((kind_q == swc_pkg::K_BIT) & opt_q)
                | ((kind_q == swc_pkg::K_DATA) & arm_q)) begin
              pullup_q <= 1'h1;
              cnt_q <= 16'h0000;
              ready_q <= (kind_q != swc_pkg::K_DATA);
              state_q <= swc_pkg::ST_PULSE;
            end else begin
              ready_q <= 1'h1;
              state_q <= swc_pkg::ST_IDLE;
            end
          end
        end
        swc_pkg::ST_PULSE: begin
          cnt_q <= cnt_q + 16'h0001;
          if (pulse_end) begin
            pullup_q <= 1'h0;
            prog_q <= 1'h0;
            rsp_valid_q <= 1'h1;
            ready_q <= 1'h1;
            state_q <= swc_pkg::ST_IDLE;
            unique case (kind_q)
              swc_pkg::K_BIT: begin
                rsp_byte_q <= last_bit_q ? swc_pkg::RSP_BIT_PUP_ONE
                                         : swc_pkg::RSP_BIT_PUP_ZERO;
              end
              swc_pkg::K_DATA: begin
                rsp_byte_q <= data_q[7] ? swc_pkg::RSP_DATA_PUP_ONE
                                        : swc_pkg::RSP_DATA_PUP_ZERO;
              end
              default: begin
                rsp_byte_q <= {cmd_q[7:2], swc_pkg::RSP_PULSE_LOW};
              end
            endcase
          end
        end
        default: begin
          state_q <= swc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops

  assign LINK.cmd_ready = ready_q;
  assign LINK.rsp_valid = rsp_valid_q;
  assign LINK.rsp_byte = rsp_byte_q;
  assign BUS_RESET_O = bus_rst_q;
  assign BUS_SLOT_O = slot_q;
  assign BUS_SLOT_BIT_O = slot_bit_q;
  assign BUS_BYTE_O = byte_q;
  assign BUS_DATA_O = data_q;
  assign BUS_SPEED_O = speed_q;
  // Slot engine runs the 12-slot search pattern per byte while set
  assign BUS_SEARCH_O = accel_q;
  assign BUS_PULLUP_O = pullup_q;
  assign BUS_PROG_O = prog_q;
  assign DATA_MODE_O = data_mode_q;

endmodule : swc_dev

// file: inc/swc_pkg.sv
package swc_pkg;

  // Command byte layout
  localparam int CMD_FLAG_HI = 7;
  localparam int CMD_FLAG_LO = 0;
  localparam int CMD_FN_HI = 6;
  localparam int CMD_FN_LO = 5;
  localparam int CMD_ARG = 4;
  localparam int CMD_SPD_HI = 3;
  localparam int CMD_SPD_LO = 2;
  localparam int CMD_OPT = 1;

  // Function codes in bits 6..5
  localparam logic [1:0] FN_BIT = 2'h0;
  localparam logic [1:0] FN_ACCEL = 2'h1;
  localparam logic [1:0] FN_RESET = 2'h2;
  localparam logic [1:0] FN_PULSE = 2'h3;

  // Bus speed codes
  localparam logic [1:0] SPD_REGULAR = 2'h0;
  localparam logic [1:0] SPD_FLEX = 2'h1;
  localparam logic [1:0] SPD_FAST = 2'h2;
  localparam logic [1:0] SPD_ALIAS = 2'h3;
  localparam logic [1:0] SPD_PULSE = 2'h3;

  // Reserved codes
  localparam logic [7:0] CODE_DATA_MODE = 8'hE1;
  localparam logic [7:0] CODE_CMD_MODE = 8'hE3;
  localparam logic [7:0] CODE_PULSE_STOP = 8'hF1;

  // Response bytes and fields
  localparam logic [7:0] RSP_BIT_PUP_ONE = 8'hEF;
  localparam logic [7:0] RSP_BIT_PUP_ZERO = 8'hEC;
  localparam logic [7:0] RSP_DATA_PUP_ONE = 8'hF6;
  localparam logic [7:0] RSP_DATA_PUP_ZERO = 8'h76;
  localparam logic [2:0] RSP_BIT_HEAD = 3'h4;
  localparam logic [1:0] RSP_RESET_HEAD = 2'h3;
  localparam logic RSP_RESERVED = 1'h0;
  localparam logic [1:0] RSP_PULSE_LOW = 2'h0;
  // Revision code, value arbitrary
  localparam logic [2:0] CHIP_REVISION = 3'h3;

  // Pulse length counter width; a length of zero means unlimited
  localparam int PULSE_CNT_W = 16;
  localparam logic [15:0] PULSE_UNLIMITED = 16'h0000;

  // Host register map
  localparam logic [3:0] REG_TX = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_RX = 4'h2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_PEND = 1;
  localparam int STAT_OVERRUN = 2;

  // Device sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUS = 2'b01,
    ST_PULSE = 2'b10
  } swc_state_t;

  // What is running on the bus, selects the response
  typedef enum logic [1:0] {
    K_RESET = 2'b00,
    K_BIT = 2'b01,
    K_DATA = 2'b10,
    K_PULSE = 2'b11
  } swc_kind_t;

endpackage : swc_pkg

// file: inc/swc_link_if.sv
`timescale 1ns/100ps
interface swc_link_if;
  logic cmd_valid;
  logic [7:0] cmd_byte;
  logic cmd_ready;
  logic rsp_valid;
  logic [7:0] rsp_byte;

  modport dev (
    input cmd_valid,
    input cmd_byte,
    output cmd_ready,
    output rsp_valid,
    output rsp_byte
  );

  modport host (
    output cmd_valid,
    output cmd_byte,
    input cmd_ready,
    input rsp_valid,
    input rsp_byte
  );
endinterface : swc_link_if

// file: core/swc_host.sv
`timescale 1ns/100ps
module swc_host (
  input wire logic CLK_I,
  input wire logic RESET_I,
  swc_link_if.host LINK,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O
);

  logic valid_q, pend_q, overrun_q;
  logic [7:0] tx_q, rx_q, rdata_q;
  logic rd_rx;

  assign rd_rx = RD_I & (ADDR_I == swc_pkg::REG_RX);

  ////////////////////////////////////////////////////////////////////////////
  // Command byte toward the device

  // A write while a byte is still offered is dropped, never overwrites it
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      valid_q <= 1'h0;
      tx_q <= 8'h00;
    end else if (valid_q) begin
      if (LINK.cmd_ready) begin
        valid_q <= 1'h0;
      end
    end else if (WR_I & (ADDR_I == swc_pkg::REG_TX)) begin
      // Software orders: reset first, disarm before search, no unlimited armed pulse
      valid_q <= 1'h1;
      tx_q <= WDATA_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response capture; a new byte wins over the clearing read

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pend_q <= 1'h0;
      overrun_q <= 1'h0;
      rx_q <= 8'h00;
    end else if (LINK.rsp_valid) begin
      rx_q <= LINK.rsp_byte;
      pend_q <= 1'h1;
      if (pend_q & ~rd_rx) begin
        overrun_q <= 1'h1;
      end
    end else if (rd_rx) begin
      pend_q <= 1'h0;
      overrun_q <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe, zero otherwise

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rdata_q <= 8'h00;
    end else if (RD_I) begin
      unique case (ADDR_I)
        swc_pkg::REG_TX: rdata_q <= tx_q;
        swc_pkg::REG_STATUS: rdata_q <= {5'h00, overrun_q, pend_q, valid_q};
        swc_pkg::REG_RX: rdata_q <= rx_q;
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign LINK.cmd_valid = valid_q;
  assign LINK.cmd_byte = tx_q;
  assign RDATA_O = rdata_q;

endmodule : swc_host

// file: bench/swc_link_monitor.sv
`timescale 1ns/100ps
module swc_link_monitor (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_byte
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  ////////////////////////////////////////////////////////////
  logic [1:0] mode_q;
  logic [7:0] op_q;
  logic pul_q;
  logic take;
  logic code;
  logic ctake;
  logic cmdf;
  assign take = cmd_valid && cmd_ready;
  assign code = cmd_byte inside {swc_pkg::CODE_DATA_MODE, swc_pkg::CODE_CMD_MODE,
    swc_pkg::CODE_PULSE_STOP};
  // Data mode bytes are not commands; check mode executes all but a repeated switch code
  // Bytes taken during a command-mode pulse are discarded unless they end it
  assign ctake = take && !code && (mode_q != 2'h1) && !pul_q;
  assign cmdf = cmd_byte[7] && cmd_byte[0];
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      mode_q <= 2'h0;
    end else if (take) begin
      case (mode_q)
        2'h0: mode_q <= (cmd_byte == 8'hE1) ? 2'h1 : 2'h0;
        2'h1: mode_q <= (cmd_byte == 8'hE3) ? 2'h2 : 2'h1;
        default: mode_q <= (cmd_byte inside {8'hE1, 8'hE3}) ? 2'h1 : 2'h0;
      endcase
    end
  end
  // Last command that owns the responses; data bytes clear it
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      op_q <= 8'h00;
    end else if (ctake && cmdf && cmd_byte[6:5] != 2'h1) begin
      op_q <= cmd_byte;
    end else if (take && mode_q != 2'h0 && !(mode_q == 2'h1 && cmd_byte == 8'hE3)) begin
      op_q <= 8'h00;
    end
  end
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pul_q <= 1'b0;
    end else if (ctake && cmdf && cmd_byte[6:5] == 2'h3 && cmd_byte[3:2] == 2'h3) begin
      pul_q <= 1'b1;
    end else if (rsp_valid) begin
      pul_q <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////
  AST_RESET_BUSY: assert property (ctake && cmdf && cmd_byte[6:5] == 2'h2 |=> !cmd_ready)
    else $error("reset command did not start bus activity");
  AST_RESET_RSP: assert property (rsp_valid && op_q[7] && op_q[6:5] == 2'h2 |->
    rsp_byte[7:6] == 2'h3 && rsp_byte[4:2] == swc_pkg::CHIP_REVISION)
    else $error("bad reset response");
  AST_BIT_RSP: assert property (rsp_valid && op_q[7:5] == 3'h4 |->
    rsp_byte == {3'h4, op_q[4:2], {2{rsp_byte[0]}}} || op_q[1] && rsp_byte inside {8'hEF, 8'hEC})
    else $error("bad single bit response");
  AST_PULSE_RSP: assert property (rsp_valid && op_q[7:5] == 3'h7 |-> rsp_byte[7:2] == op_q[7:2])
    else $error("pulse response does not echo command");
  AST_ACCEL_QUIET: assert property (ctake && cmdf && cmd_byte[6:5] == 2'h1 |=>
    cmd_ready && !rsp_valid ##1 !rsp_valid)
    else $error("accelerator command caused activity");
  AST_CODES_READY: assert property (take && mode_q == 2'h0 && code && !pul_q |=>
    cmd_ready && !rsp_valid)
    else $error("reserved code caused activity");
  AST_ILLEGAL_QUIET: assert property (ctake && (!cmdf || cmd_byte[6:5] == 2'h3 &&
    cmd_byte[3:2] != 2'h3) |=> !rsp_valid [*3])
    else $error("illegal command answered");
  AST_F1_ENDS: assert property (take && mode_q == 2'h0 && cmd_byte == 8'hF1 && pul_q |=>
    rsp_valid)
    else $error("termination code did not end pulse");
  AST_CHECK_WRITE: assert property (take && mode_q == 2'h2 && cmd_byte == 8'hE3 |=> !cmd_ready)
    else $error("repeated switch code not written");
endmodule : swc_link_monitor

// file: bench/single_wire_comm_command_decoder_tb.sv
`timescale 1ns/100ps
module single_wire_comm_command_decoder_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [15:0] pcyc = 16'h0014;
  logic done = 1'b0;
  logic [7:0] res = 8'h00;
  logic dem = 1'b0;
  logic bres, bslot, bbit, bbyte, search, pup, prog, dmode;
  logic [7:0] bdata;
  logic [1:0] spd;
  logic [1:0] pres = 2'h1;
  logic sbit = 1'b0;
  logic [7:0] cnt = 8'h00;
  logic [7:0] st;
  logic [7:0] d;
  int err_total = 0;
  int num_checks = 0;
  swc_link_if link ();
  swc_host i_swc_host (.CLK_I(clk), .RESET_I(rst), .LINK(link), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata));
  swc_dev i_swc_dev (.CLK_I(clk), .RESET_I(rst), .LINK(link), .PULSE_CYCLES_I(pcyc),
    .BUS_DONE_I(done), .BUS_RESULT_I(res), .BUS_DEMAND_END_I(dem), .BUS_RESET_O(bres),
    .BUS_SLOT_O(bslot), .BUS_SLOT_BIT_O(bbit), .BUS_BYTE_O(bbyte), .BUS_DATA_O(bdata),
    .BUS_SPEED_O(spd), .BUS_SEARCH_O(search), .BUS_PULLUP_O(pup), .BUS_PROG_O(prog),
    .DATA_MODE_O(dmode));
  swc_link_monitor i_swc_link_monitor (.CLK_I(clk), .RESET_I(rst),
    .cmd_valid(link.cmd_valid), .cmd_byte(link.cmd_byte), .cmd_ready(link.cmd_ready),
    .rsp_valid(link.rsp_valid), .rsp_byte(link.rsp_byte));
  always #20 clk = ~clk;
  // Slot engine stand-in: a data byte reads back as written
  always @(posedge clk) begin
    done <= (cnt == 8'h01);
    if (bres || bslot || bbyte) begin
      cnt <= 8'h06;
      res <= bres ? {6'h00, pres} : bslot ? {7'h00, sbit} : bdata;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg
  // Transmit is dropped while busy, so wait it out first
  task automatic send(input logic [7:0] b);
    st = 8'h01;
    for (int i = 0; i < 300 && st[0]; i++) rd_reg(swc_pkg::REG_STATUS, st);
    // A busy flag that never clears counts as a mismatch
    chk(st & 8'h01, 8'h00);
    wr_reg(swc_pkg::REG_TX, b);
  endtask : send
  task automatic get(input logic [7:0] exp);
    st = 8'h00;
    for (int i = 0; i < 300 && !st[1]; i++) rd_reg(swc_pkg::REG_STATUS, st);
    // A response that never arrives counts as a mismatch
    chk(st & 8'h02, 8'h02);
    rd_reg(swc_pkg::REG_RX, st);
    chk(st, exp);
  endtask : get
  task automatic quiet();
    repeat (30) @(posedge clk);
    rd_reg(swc_pkg::REG_STATUS, st);
    chk(st & 8'h02, 8'h00);
  endtask : quiet
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      pres = s[1:0];
      send(8'hC1 | {4'h0, s[1:0], 2'h0});
      get({2'h3, swc_pkg::RSP_RESERVED, swc_pkg::CHIP_REVISION, s[1:0]});
      chk({6'h0, spd}, (s == 3) ? 8'h00 : {6'h0, s[1:0]});
    end
    send(8'hB5);
    quiet();
    chk({5'h0, search, spd}, 8'h05);
    for (int v = 0; v < 2; v++) begin
      sbit = v[0];
      send(8'h89 | {3'h0, v[0], 4'h0});
      get({3'h4, v[0], 2'h2, v[0], v[0]});
      chk({4'h0, search, bbit, spd}, {4'h0, 1'b1, v[0], 2'h2});
    end
    send(8'hA1);
    quiet();
    chk({5'h0, search, spd}, 8'h00);
    for (int v = 0; v < 2; v++) begin
      sbit = v[0];
      send(8'h93);
      get({6'h24, v[0], v[0]});
      chk({7'h0, pup}, 8'h01);
      get(v ? 8'hEF : 8'hEC);
    end
    send(8'h93);
    repeat (40) @(posedge clk);
    rd_reg(swc_pkg::REG_STATUS, st);
    chk(st, 8'h06);
    get(8'hEF);
    rd_reg(swc_pkg::REG_STATUS, st);
    chk(st, 8'h00);
    send(8'hC8);
    send(8'hE5);
    quiet();
    chk({4'h0, pup, prog, spd}, 8'h00);
    @(posedge clk);
    pcyc <= 16'h0000;
    send(8'hFD);
    repeat (8) @(posedge clk);
    chk({6'h0, pup, prog}, 8'h01);
    send(swc_pkg::CODE_PULSE_STOP);
    get(8'hFC);
    chk({6'h0, pup, prog}, 8'h00);
    @(posedge clk);
    pcyc <= 16'h0014;
    send(8'hEF);
    get(8'hEC);
    send(swc_pkg::CODE_DATA_MODE);
    quiet();
    chk({7'h0, dmode}, 8'h01);
    for (int k = 0; k < 2; k++) begin
      d = k ? 8'h35 : 8'hA5;
      send(d);
      get(d);
      get(k ? 8'h76 : 8'hF6);
    end
    send(swc_pkg::CODE_CMD_MODE);
    send(swc_pkg::CODE_CMD_MODE);
    get(8'hE3);
    get(8'hF6);
    send(swc_pkg::CODE_CMD_MODE);
    @(posedge clk);
    pcyc <= 16'h0000;
    send(8'hED);
    repeat (8) @(posedge clk);
    dem <= 1'b1;
    @(posedge clk);
    dem <= 1'b0;
    get(8'hEC);
    chk({7'h0, dmode}, 8'h00);
    send(swc_pkg::CODE_DATA_MODE);
    send(8'h5A);
    get(8'h5A);
    quiet();
    rd_reg(swc_pkg::REG_TX, st);
    chk(st, 8'h5A);
    rd_reg(4'hF, st);
    chk(st, 8'h00);
    give_verdict();
  end
endmodule : single_wire_comm_command_decoder_tb
